// ---- src/ebu_pkg.sv ----
// Constants, types and timing fields shared by the external bus unit.
// Assumes a single 100 MHz CPU-side clock; no bus reaches these settings.
package ebu_pkg;

    // Bus modes: single chip, or data width and lane sharing
    typedef enum logic [2:0]
    {
        EBU_MODE_SINGLE    = 3'h0,
        EBU_MODE_DEMUX16   = 3'h1,
        EBU_MODE_MUX16     = 3'h2,
        EBU_MODE_MUX8      = 3'h3,
        EBU_MODE_DEMUX8    = 3'h4
    } ebu_mode_t;

    // Address space size select
    typedef enum logic [1:0]
    {
        EBU_SPACE_64K  = 2'h0,
        EBU_SPACE_256K = 2'h1,
        EBU_SPACE_1M   = 2'h2,
        EBU_SPACE_4M   = 2'h3
    } ebu_space_t;

    // Access sequencer, Gray coded from IDLE up to TRI
    typedef enum logic [2:0]
    {
        EBU_ST_IDLE  = 3'b000,
        EBU_ST_ADDR  = 3'b001,
        EBU_ST_DLY   = 3'b011,
        EBU_ST_DATA  = 3'b010,
        EBU_ST_TRI   = 3'b110
    } ebu_state_t;

    localparam int ADDR_W      = 22;
    localparam int UPPER_W     = 6;
    localparam int LOW_W       = 16;
    localparam int CS_NUM      = 4;
    localparam int TIME_W      = 4;
    localparam int RANGES      = 4;

    // Variant straps: chip-select count of each variant
    localparam int CS_NONE     = 0;
    localparam int CS_TWO      = 2;
    localparam int CS_FOUR     = 4;

    // Upper-address bit counts per space
    localparam logic [2:0] UP_BITS_4M   = 3'h6;
    localparam logic [2:0] UP_BITS_1M   = 3'h4;
    localparam logic [2:0] UP_BITS_256K = 3'h2;
    localparam logic [2:0] UP_BITS_64K  = 3'h0;

    localparam logic [TIME_W-1:0] TIME_ZERO  = 4'h0;
    localparam logic [TIME_W-1:0] TIME_ONE   = 4'h1;
    localparam logic [UPPER_W-1:0] UPPER_ZERO = 6'h00;
    localparam logic [LOW_W-1:0]   LOW_ZERO   = 16'h0000;
    localparam logic [CS_NUM-1:0]  CS_IDLE    = 4'hf;

endpackage

// ---- src/ebu_range_match.sv ----
// One address-range comparator of the external bus unit.
// Assumes base and mask are static while accesses run.
`timescale 1ns/1ps
`default_nettype none
module ebu_range_match
(
    input  wire logic [ebu_pkg::ADDR_W-1:0] addr_in,   // Access address
    input  wire logic [ebu_pkg::ADDR_W-1:0] base_in,   // Range base
    input  wire logic [ebu_pkg::ADDR_W-1:0] mask_in,   // Ones = compared
    input  wire logic                       en_in,     // Range enabled
    output logic                            hit_out    // Address in range
);

    // Masked compare keeps ranges power-of-two aligned and cheap
    always_comb
    begin
        hit_out = en_in && ((addr_in & mask_in) == (base_in & mask_in));
    end

endmodule
`default_nettype wire

// ---- src/ebu_upper_addr.sv ----
// Upper-address port driver for the external bus unit.
// Assumes the address is held stable for the whole access.
`timescale 1ns/1ps
`default_nettype none
module ebu_upper_addr
(
    input  wire logic [ebu_pkg::UPPER_W-1:0] upper_in,  // Address 21..16
    input  wire ebu_pkg::ebu_space_t         space_in,  // Space size
    output logic [ebu_pkg::UPPER_W-1:0]      upper_out, // Pin values
    output logic [ebu_pkg::UPPER_W-1:0]      oe_out     // Pin enables
);

    always_comb
    begin
        case (space_in)
            ebu_pkg::EBU_SPACE_4M:   oe_out = 6'h3f;
            ebu_pkg::EBU_SPACE_1M:   oe_out = 6'h0f;
            ebu_pkg::EBU_SPACE_256K: oe_out = 6'h03;
            default:                 oe_out = ebu_pkg::UPPER_ZERO;
        endcase
        upper_out = upper_in & oe_out;
    end

endmodule
`default_nettype wire

// ---- src/ebu_top.sv ----
// External bus unit: sequences CPU accesses onto external memory pins.
// Assumes the CPU holds a request until acknowledged; pins are synchronous.
`timescale 1ns/1ps
`default_nettype none
module ebu_top
#(
    parameter int CS_COUNT   = ebu_pkg::CS_FOUR, // Chip selects present
    parameter bit DEMUX_OK   = 1'b1              // Demux modes available
)
(
    input  wire logic                        ref_clk_in,   // CPU clock
    input  wire logic                        rst_n_in,     // Sync reset
    input  wire ebu_pkg::ebu_mode_t          mode_in,      // Bus mode
    input  wire ebu_pkg::ebu_space_t         space_in,     // Space size
    input  wire logic [ebu_pkg::TIME_W-1:0]  cyc_in [ebu_pkg::RANGES],
    input  wire logic [ebu_pkg::TIME_W-1:0]  tri_in [ebu_pkg::RANGES],
    input  wire logic [ebu_pkg::TIME_W-1:0]  ale_in [ebu_pkg::RANGES],
    input  wire logic [ebu_pkg::TIME_W-1:0]  rwd_in [ebu_pkg::RANGES],
    input  wire logic [ebu_pkg::ADDR_W-1:0]  base_in [ebu_pkg::RANGES],
    input  wire logic [ebu_pkg::ADDR_W-1:0]  mask_in [ebu_pkg::RANGES],
    input  wire logic [ebu_pkg::RANGES-1:0]  range_en_in,  // Range enables
    input  wire logic                        req_in,       // Access request
    input  wire logic                        wr_in,        // 1 = write
    input  wire logic                        byte_in,      // 1 = byte
    input  wire logic [ebu_pkg::ADDR_W-1:0]  addr_in,      // Byte address
    input  wire logic [15:0]                 wdata_in,     // Write data
    output logic                             ack_out,      // Access done
    output logic [15:0]                      rdata_out,    // Read data
    output logic                             mode_err_out, // Mode refused
    input  wire logic [15:0]                 ad_in,        // Shared lanes in
    output logic [15:0]                      ad_out,       // Shared lanes
    output logic [15:0]                      ad_oe_out,    // Shared enables
    output logic [15:0]                      addr_lo_out,  // Dedicated lanes
    output logic                             addr_lo_oe_out, // Ded. enable
    output logic [ebu_pkg::UPPER_W-1:0]      addr_hi_out,  // Upper address
    output logic [ebu_pkg::UPPER_W-1:0]      addr_hi_oe_out, // Upper enables
    output logic                             ale_out,      // Latch strobe
    output logic                             rd_n_out,     // Read strobe
    output logic                             wr_n_out,     // Write strobe
    output logic                             bhe_n_out,    // High byte en
    output logic [ebu_pkg::CS_NUM-1:0]       cs_n_out      // Chip selects
);

    // Range decode results
    logic [ebu_pkg::RANGES-1:0]  hit;
    logic [ebu_pkg::UPPER_W-1:0] up_val;
    logic [ebu_pkg::UPPER_W-1:0] up_oe;

    genvar gi;
    generate
        for (gi = 0; gi < ebu_pkg::RANGES; gi++)
        begin : g_rng
            ebu_range_match u_match
            (
                .addr_in (addr_in),
                .base_in (base_in[gi]),
                .mask_in (mask_in[gi]),
                .en_in   (range_en_in[gi]),
                .hit_out (hit[gi])
            );
        end
    endgenerate

    ebu_pkg::ebu_state_t          st_r, st_nxt;
    ebu_pkg::ebu_mode_t           mode_r, mode_nxt;
    logic [ebu_pkg::TIME_W-1:0]   cnt_r, cnt_nxt;
    logic [ebu_pkg::TIME_W-1:0]   t_cyc_r, t_cyc_nxt;
    logic [ebu_pkg::TIME_W-1:0]   t_tri_r, t_tri_nxt;
    logic [ebu_pkg::TIME_W-1:0]   t_rwd_r, t_rwd_nxt;
    logic [1:0]                   sel_r, sel_nxt;
    logic                         wr_r, wr_nxt, byte_r, byte_nxt;
    logic [ebu_pkg::ADDR_W-1:0]   a_r, a_nxt;
    logic [15:0]                  wd_r, wd_nxt;
    logic                         demux_seen_r, demux_seen_nxt;
    logic                         ack_r, ack_nxt, err_r, err_nxt;
    logic [15:0]                  rd_r, rd_nxt;
    logic [15:0]                  ad_r, ad_nxt, adoe_r, adoe_nxt;
    logic [15:0]                  alo_r, alo_nxt;
    logic                         aloe_r, aloe_nxt;
    logic                         ale_r, ale_nxt, rdn_r, rdn_nxt;
    logic                         wrn_r, wrn_nxt, bhen_r, bhen_nxt;
    logic [ebu_pkg::CS_NUM-1:0]   csn_r, csn_nxt;
    logic [ebu_pkg::UPPER_W-1:0]  hi_r, hi_nxt, hioe_r, hioe_nxt;
    logic                         is_mux, is_demux, bus8;
    logic [1:0]                   pick;
    logic [ebu_pkg::ADDR_W-1:0]   a_cut;

    // unused upper bits cut according to space
    ebu_upper_addr u_upper
    (
        .upper_in  (a_r[ebu_pkg::ADDR_W-1:ebu_pkg::LOW_W]),
        .space_in  (space_in),
        .upper_out (up_val),
        .oe_out    (up_oe)
    );

    // Mode classification and range priority, lowest index wins
    always_comb
    begin
        is_mux   = (mode_r == ebu_pkg::EBU_MODE_MUX16) ||
                   (mode_r == ebu_pkg::EBU_MODE_MUX8);
        is_demux = (mode_r == ebu_pkg::EBU_MODE_DEMUX16) ||
                   (mode_r == ebu_pkg::EBU_MODE_DEMUX8);
        bus8     = (mode_r == ebu_pkg::EBU_MODE_MUX8) ||
                   (mode_r == ebu_pkg::EBU_MODE_DEMUX8);
        pick = 2'h0;
        for (int i = ebu_pkg::RANGES - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                pick = i[1:0];
            end
        end
        a_cut = addr_in;
    end

    // Sequencer next state and pin values
    always_comb
    begin
        st_nxt = st_r;
        mode_nxt = mode_r;
        cnt_nxt = cnt_r;
        t_cyc_nxt = t_cyc_r;
        t_tri_nxt = t_tri_r;
        t_rwd_nxt = t_rwd_r;
        sel_nxt = sel_r;
        wr_nxt = wr_r;
        byte_nxt = byte_r;
        a_nxt = a_r;
        wd_nxt = wd_r;
        demux_seen_nxt = demux_seen_r;
        ack_nxt = 1'b0;
        err_nxt = err_r;
        rd_nxt = rd_r;
        ad_nxt = ad_r;
        adoe_nxt = adoe_r;
        alo_nxt = alo_r;
        aloe_nxt = aloe_r;
        ale_nxt = 1'b0;
        rdn_nxt = 1'b1;
        wrn_nxt = 1'b1;
        bhen_nxt = bhen_r;
        csn_nxt = csn_r;
        hi_nxt = hi_r;
        hioe_nxt = hioe_r;
        case (st_r)
            ebu_pkg::EBU_ST_IDLE:
            begin
                adoe_nxt = 16'h0000;
                csn_nxt = ebu_pkg::CS_IDLE;
                if ((mode_in == ebu_pkg::EBU_MODE_DEMUX16 ||
                     mode_in == ebu_pkg::EBU_MODE_DEMUX8) && !DEMUX_OK)
                begin
                    err_nxt = 1'b1;
                end
                else
                begin
                    err_nxt = 1'b0;
                    mode_nxt = mode_in;
                end
                // dedicated lanes stay once demux was used
                if (mode_nxt == ebu_pkg::EBU_MODE_DEMUX16 ||
                    mode_nxt == ebu_pkg::EBU_MODE_DEMUX8)
                begin
                    demux_seen_nxt = 1'b1;
                end
                // single chip never starts a cycle
                if (req_in && mode_r != ebu_pkg::EBU_MODE_SINGLE)
                begin
                    sel_nxt = pick;
                    t_cyc_nxt = cyc_in[pick];
                    t_tri_nxt = tri_in[pick];
                    t_rwd_nxt = rwd_in[pick];
                    cnt_nxt = ale_in[pick];
                    wr_nxt = wr_in;
                    byte_nxt = byte_in;
                    a_nxt = a_cut;
                    wd_nxt = wdata_in;
                    st_nxt = ebu_pkg::EBU_ST_ADDR;
                    csn_nxt = ebu_pkg::CS_IDLE;
                    if (int'(pick) < CS_COUNT)
                    begin
                        csn_nxt[pick] = 1'b0;
                    end
                    // high byte enable for word or odd byte
                    bhen_nxt = !(!byte_in || addr_in[0]);
                    if (is_mux)
                    begin
                        ad_nxt = a_cut[ebu_pkg::LOW_W-1:0];
                        adoe_nxt = 16'hffff;
                        ale_nxt = 1'b1;
                    end
                    alo_nxt = a_cut[ebu_pkg::LOW_W-1:0];
                    aloe_nxt = is_demux || demux_seen_r;
                end
            end
            ebu_pkg::EBU_ST_ADDR:
            begin
                ale_nxt = is_mux && (cnt_r != ebu_pkg::TIME_ZERO);
                if (cnt_r == ebu_pkg::TIME_ZERO)
                begin
                    cnt_nxt = t_rwd_r;
                    st_nxt = ebu_pkg::EBU_ST_DLY;
                    adoe_nxt = 16'h0000;
                end
                else
                begin
                    cnt_nxt = cnt_r - ebu_pkg::TIME_ONE;
                end
            end
            ebu_pkg::EBU_ST_DLY:
            begin
                if (cnt_r == ebu_pkg::TIME_ZERO)
                begin
                    cnt_nxt = t_cyc_r;
                    st_nxt = ebu_pkg::EBU_ST_DATA;
                    // Strobe and write data launch as DATA begins, so the
                    // strobe spans every DATA cycle even with zero count
                    rdn_nxt = wr_r;
                    wrn_nxt = !wr_r;
                    if (wr_r)
                    begin
                        ad_nxt = (bus8 && a_r[0]) ? {8'h00, wd_r[15:8]} : wd_r;
                        adoe_nxt = bus8 ? 16'h00ff : 16'hffff;
                    end
                end
                else
                begin
                    cnt_nxt = cnt_r - ebu_pkg::TIME_ONE;
                end
            end
            ebu_pkg::EBU_ST_DATA:
            begin
                // data phase on the shared lanes
                if (cnt_r == ebu_pkg::TIME_ZERO)
                begin
                    if (!wr_r)
                    begin
                        rd_nxt = bus8 ? {8'h00, ad_in[7:0]} : ad_in;
                    end
                    cnt_nxt = t_tri_r;
                    st_nxt = ebu_pkg::EBU_ST_TRI;
                end
                else
                begin
                    rdn_nxt = wr_r;
                    wrn_nxt = !wr_r;
                    cnt_nxt = cnt_r - ebu_pkg::TIME_ONE;
                end
            end
            ebu_pkg::EBU_ST_TRI:
            begin
                adoe_nxt = 16'h0000;
                csn_nxt = ebu_pkg::CS_IDLE;
                if (cnt_r == ebu_pkg::TIME_ZERO)
                begin
                    ack_nxt = 1'b1;
                    st_nxt = ebu_pkg::EBU_ST_IDLE;
                end
                else
                begin
                    cnt_nxt = cnt_r - ebu_pkg::TIME_ONE;
                end
            end
            default:
            begin
                st_nxt = ebu_pkg::EBU_ST_IDLE;
            end
        endcase
        // upper lines only in external modes
        hi_nxt = (mode_r == ebu_pkg::EBU_MODE_SINGLE) ?
                 ebu_pkg::UPPER_ZERO : up_val;
        hioe_nxt = (mode_r == ebu_pkg::EBU_MODE_SINGLE) ?
                   ebu_pkg::UPPER_ZERO : up_oe;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            st_r <= ebu_pkg::EBU_ST_IDLE;
            mode_r <= ebu_pkg::EBU_MODE_SINGLE;
            cnt_r <= ebu_pkg::TIME_ZERO;
            t_cyc_r <= ebu_pkg::TIME_ZERO;
            t_tri_r <= ebu_pkg::TIME_ZERO;
            t_rwd_r <= ebu_pkg::TIME_ZERO;
            sel_r <= 2'h0;
            wr_r <= 1'b0;
            byte_r <= 1'b0;
            a_r <= '0;
            wd_r <= ebu_pkg::LOW_ZERO;
            demux_seen_r <= 1'b0;
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rd_r <= ebu_pkg::LOW_ZERO;
            ad_r <= ebu_pkg::LOW_ZERO;
            adoe_r <= ebu_pkg::LOW_ZERO;
            alo_r <= ebu_pkg::LOW_ZERO;
            aloe_r <= 1'b0;
            ale_r <= 1'b0;
            rdn_r <= 1'b1;
            wrn_r <= 1'b1;
            bhen_r <= 1'b1;
            csn_r <= ebu_pkg::CS_IDLE;
            hi_r <= ebu_pkg::UPPER_ZERO;
            hioe_r <= ebu_pkg::UPPER_ZERO;
        end
        else
        begin
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            cnt_r <= cnt_nxt;
            t_cyc_r <= t_cyc_nxt;
            t_tri_r <= t_tri_nxt;
            t_rwd_r <= t_rwd_nxt;
            sel_r <= sel_nxt;
            wr_r <= wr_nxt;
            byte_r <= byte_nxt;
            a_r <= a_nxt;
            wd_r <= wd_nxt;
            demux_seen_r <= demux_seen_nxt;
            ack_r <= ack_nxt;
            err_r <= err_nxt;
            rd_r <= rd_nxt;
            ad_r <= ad_nxt;
            adoe_r <= adoe_nxt;
            alo_r <= alo_nxt;
            aloe_r <= aloe_nxt;
            ale_r <= ale_nxt;
            rdn_r <= rdn_nxt;
            wrn_r <= wrn_nxt;
            bhen_r <= bhen_nxt;
            csn_r <= csn_nxt;
            hi_r <= hi_nxt;
            hioe_r <= hioe_nxt;
        end
    end

    // Outputs straight from flops
    assign ack_out = ack_r;
    assign rdata_out = rd_r;
    assign mode_err_out = err_r;
    assign ad_out = ad_r;
    assign ad_oe_out = adoe_r;
    assign addr_lo_out = alo_r;
    assign addr_lo_oe_out = aloe_r;
    assign addr_hi_out = hi_r;
    assign addr_hi_oe_out = hioe_r;
    assign ale_out = ale_r;
    assign rd_n_out = rdn_r;
    assign wr_n_out = wrn_r;
    assign bhe_n_out = bhen_r;
    assign cs_n_out = csn_r;

endmodule
`default_nettype wire

// ---- sim/ebu_mem_model.sv ----
// Behavioural external RAM answering the bus unit's cycles.
// Assumes one access at a time; 32 cells keyed by address bits 4:0.
`timescale 1ns/1ps
`default_nettype none
module ebu_mem_model
(
    input  wire logic        clk_in,   // Bus clock
    input  wire logic [15:0] ad_in,    // Shared lanes as seen on the wire
    input  wire logic [15:0] lo_in,    // Dedicated address lanes
    input  wire logic        lo_oe_in, // Dedicated lanes driven
    input  wire logic        ale_in,   // Address latch strobe
    input  wire logic        rd_n_in,  // Read strobe
    input  wire logic        wr_n_in,  // Write strobe
    input  wire logic [3:0]  cs_n_in,  // Chip selects
    output logic      [15:0] ad_out    // Shared lanes driven by memory
);
    logic [15:0] mem_r [32];
    logic [15:0] lat_r;
    logic [15:0] last_r = 16'h0000;
    logic [4:0]  a;
    logic        sel;
    // Address comes from the external latch or the dedicated lanes
    assign a   = lo_oe_in ? lo_in[4:0] : lat_r[4:0];
    assign sel = (cs_n_in != 4'hf);
    always @(posedge clk_in)
    begin
        if (ale_in)
            lat_r <= ad_in;
        if (sel && !wr_n_in)
            mem_r[a] <= ad_in;
        last_r <= ad_out;
    end
    // answer as RAM; released lanes toggle, never hold old data
    assign ad_out = (sel && !rd_n_in) ? mem_r[a] : ~last_r;
endmodule
`default_nettype wire

// ---- sim/ebu_top_monitor.sv ----
// Pin assertions for the bus unit, bound into every ebu_top.
// Assumes mode and space change only while the unit is idle.
`timescale 1ns/1ps
`default_nettype none
module ebu_top_monitor
#(
    parameter int CS_COUNT = 4,   // Chip selects present
    parameter bit DEMUX_OK = 1'b1 // Demux modes available
)
(
    input wire logic                       ref_clk_in,     // Clock
    input wire logic                       rst_n_in,       // Sync reset
    input wire ebu_pkg::ebu_mode_t         mode_in,        // Bus mode
    input wire ebu_pkg::ebu_space_t        space_in,       // Space size
    input wire logic                       byte_in,        // Byte access
    input wire logic                       mode_err_out,   // Mode refused
    input wire logic [15:0]                ad_oe_out,      // Shared enables
    input wire logic                       addr_lo_oe_out, // Lane enable
    input wire logic [ebu_pkg::UPPER_W-1:0] addr_hi_oe_out, // Upper enables
    input wire logic                       ale_out,        // Latch strobe
    input wire logic                       rd_n_out,       // Read strobe
    input wire logic                       wr_n_out,       // Write strobe
    input wire logic                       bhe_n_out,      // High byte
    input wire logic [ebu_pkg::CS_NUM-1:0] cs_n_out        // Selects
);
    logic       mux;
    logic       dmx;
    logic [6:0] hi_mask;
    logic [3:0] cs_free;
    // Decoded settings; upper mask widens by two bits per step of space size
    assign mux = (mode_in == ebu_pkg::EBU_MODE_MUX16) ||
                 (mode_in == ebu_pkg::EBU_MODE_MUX8);
    assign dmx = (mode_in == ebu_pkg::EBU_MODE_DEMUX16) ||
                 (mode_in == ebu_pkg::EBU_MODE_DEMUX8);
    assign hi_mask = (7'h01 << {space_in, 1'b0}) - 7'h01;
    assign cs_free = 4'((5'h01 << CS_COUNT) - 5'h01);
    // One clock domain for every property
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        !rst_n_in |=> (rd_n_out && wr_n_out && !ale_out &&
        cs_n_out == 4'hf && ad_oe_out == 16'h0000))
        else $error("pins active after reset");
    AST_SINGLE_QUIET: assert property (
        (mode_in == ebu_pkg::EBU_MODE_SINGLE)[*3] |->
        (cs_n_out == 4'hf && rd_n_out && wr_n_out))
        else $error("access in single chip mode");
    AST_MUX_ADDR: assert property (
        ale_out && mux |-> ad_oe_out == 16'hffff && rd_n_out && wr_n_out)
        else $error("strobe without address on lanes");
    AST_MUX_DATA: assert property (
        $fell(ale_out) && mux |-> ##[0:16] (!rd_n_out || !wr_n_out))
        else $error("no data phase after address");
    AST_READ_RELEASE: assert property (
        !rd_n_out |-> ad_oe_out == 16'h0000 && wr_n_out)
        else $error("lanes driven during read");
    AST_DEMUX_LANES: assert property (
        cs_n_out != 4'hf && dmx |-> addr_lo_oe_out)
        else $error("dedicated lanes idle in demux");
    AST_HI_LINES: assert property (
        cs_n_out != 4'hf && $stable(space_in) |->
        addr_hi_oe_out == hi_mask[5:0])
        else $error("upper lines wrong for space");
    AST_CS_VARIANT: assert property (
        (cs_n_out | cs_free) == 4'hf && $countones(~cs_n_out) <= 1)
        else $error("bad chip select pattern");
    AST_NO_REFUSE: assert property (
        mode_err_out |-> !DEMUX_OK)
        else $error("mode refused on full variant");
    AST_BHE_WORD: assert property (
        (!rd_n_out || !wr_n_out) && !byte_in |-> !bhe_n_out)
        else $error("high byte off for word");
endmodule
bind ebu_top ebu_top_monitor #(.CS_COUNT(CS_COUNT), .DEMUX_OK(DEMUX_OK)) mon
(
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .mode_in(mode_in),
    .space_in(space_in), .byte_in(byte_in), .mode_err_out(mode_err_out),
    .ad_oe_out(ad_oe_out), .addr_lo_oe_out(addr_lo_oe_out),
    .addr_hi_oe_out(addr_hi_oe_out), .ale_out(ale_out),
    .rd_n_out(rd_n_out), .wr_n_out(wr_n_out), .bhe_n_out(bhe_n_out),
    .cs_n_out(cs_n_out)
);
`default_nettype wire

// ---- sim/ebu_top_tb_top.sv ----
// Self-checking bench: bus unit against a behavioural memory.
// Assumes four selects and demux support in the unit.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module ebu_top_tb_top;
    typedef struct {
        ebu_pkg::ebu_mode_t m;
        logic w;
        logic b;
        logic [21:0] a;
        logic [15:0] d;
        int l;
    } ebu_row_t;
    localparam ebu_pkg::ebu_mode_t MX = ebu_pkg::EBU_MODE_MUX16;
    localparam ebu_pkg::ebu_mode_t DX = ebu_pkg::EBU_MODE_DEMUX16;
    localparam ebu_pkg::ebu_mode_t M8 = ebu_pkg::EBU_MODE_MUX8;
    localparam ebu_pkg::ebu_mode_t D8 = ebu_pkg::EBU_MODE_DEMUX8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    ebu_pkg::ebu_mode_t  mode;
    ebu_pkg::ebu_space_t space;
    logic [3:0]  cyc [4];
    logic [3:0]  trd [4];
    logic [3:0]  alt [4];
    logic [3:0]  rwd [4];
    logic [21:0] base [4];
    logic [21:0] mask [4];
    logic [3:0]  ren, cs_n;
    logic        req, wr, bt, ack, err, lo_oe, ale, rd_n, wr_n, bhe_n;
    logic [21:0] addr;
    logic [15:0] wdata, rdata, adi, ado, adoe, lo, bus;
    logic [5:0]  hi, hi_oe;
    logic [5:0]  hmask [4] = '{6'h00, 6'h03, 6'h0f, 6'h3f};
    int          mismatches = 0;
    int          checked = 0;
    ebu_row_t    rows [10];
    // Wire level of the shared lanes from the unit's enables; memory drives the rest
    assign bus = (ado & adoe) | (adi & ~adoe);
    always #5 clk = ~clk;
    ebu_top uut
    (
        .ref_clk_in(clk), .rst_n_in(rst_n), .mode_in(mode),
        .space_in(space), .cyc_in(cyc), .tri_in(trd), .ale_in(alt),
        .rwd_in(rwd), .base_in(base), .mask_in(mask), .range_en_in(ren),
        .req_in(req), .wr_in(wr), .byte_in(bt), .addr_in(addr),
        .wdata_in(wdata), .ack_out(ack), .rdata_out(rdata),
        .mode_err_out(err), .ad_in(bus), .ad_out(ado), .ad_oe_out(adoe),
        .addr_lo_out(lo), .addr_lo_oe_out(lo_oe), .addr_hi_out(hi),
        .addr_hi_oe_out(hi_oe), .ale_out(ale), .rd_n_out(rd_n),
        .wr_n_out(wr_n), .bhe_n_out(bhe_n), .cs_n_out(cs_n)
    );
    ebu_mem_model mem
    (
        .clk_in(clk), .ad_in(bus), .lo_in(lo), .lo_oe_in(lo_oe),
        .ale_in(ale), .rd_n_in(rd_n), .wr_n_in(wr_n), .cs_n_in(cs_n),
        .ad_out(adi)
    );
    // Final counts and verdict; also the watchdog's exit
    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One access; mode is loaded an idle edge before the request
    task automatic access(input ebu_row_t r);
        int n;
        mode = r.m;
        @(posedge clk) #1;
        req = 1'b1;
        wr = r.w;
        bt = r.b;
        addr = r.a;
        wdata = r.d;
        n = 0;
        do
        begin
            @(posedge clk) #1;
            n++;
            if (n == 2)
            begin
                `CHK("select", r.a[21] ? 4'hd : 4'he, cs_n)
                `CHK("upper_oe", hmask[space], hi_oe)
            end
        end while (ack !== 1'b1 && n < 40);
        req = 1'b0;
        `CHK("latency", r.l, n)
        if (!r.w)
            `CHK("rdata", r.d, rdata)
    endtask
    // Hang guard sized well beyond the expected run
    initial
    begin
        #50000;
        mismatches++;
        summarize();
    end
    initial
    begin
        mode = ebu_pkg::EBU_MODE_SINGLE;
        space = ebu_pkg::EBU_SPACE_4M;
        // Range 0 fast, lower half; range 1 slow, upper half
        cyc = '{4'h0, 4'h2, 4'h0, 4'h0};
        trd = '{4'h0, 4'h1, 4'h0, 4'h0};
        alt = '{4'h0, 4'h1, 4'h0, 4'h0};
        rwd = '{4'h0, 4'h1, 4'h0, 4'h0};
        base = '{22'h00_0000, 22'h20_0000, 22'h00_0000, 22'h00_0000};
        mask = '{22'h20_0000, 22'h20_0000, 22'h00_0000, 22'h00_0000};
        ren = 4'h3;
        {req, wr, bt, addr, wdata} = '0;
        rows = '{'{MX, 1, 0, 22'h00_0004, 16'h1234, 5},
                 '{MX, 0, 0, 22'h00_0004, 16'h1234, 5},
                 '{DX, 1, 0, 22'h00_0008, 16'h5678, 5},
                 '{DX, 0, 0, 22'h00_0008, 16'h5678, 5},
                 '{M8, 1, 1, 22'h00_0011, 16'hab00, 5},
                 '{M8, 0, 1, 22'h00_0011, 16'h00ab, 5},
                 '{D8, 1, 1, 22'h00_0012, 16'h00cd, 5},
                 '{D8, 0, 1, 22'h00_0012, 16'h00cd, 5},
                 '{MX, 1, 0, 22'h20_0006, 16'h9abc, 10},
                 '{MX, 0, 0, 22'h20_0006, 16'h9abc, 10}};
        repeat (20) @(posedge clk) #1;
        `CHK("rst_cs", 4'hf, cs_n)
        `CHK("rst_rw", 2'b11, {rd_n, wr_n})
        rst_n = 1'b1;
        // Requests in single chip mode are never answered
        req = 1'b1;
        repeat (10)
        begin
            @(posedge clk) #1;
            `CHK("single", 5'h0f, {ack, cs_n})
        end
        req = 1'b0;
        $display("single chip test done");
        foreach (rows[i])
        begin
            access(rows[i]);
            $display("row %0d done", i);
        end
        // Each space size shows its own upper lines
        for (int s = 0; s < 4; s++)
        begin
            space = ebu_pkg::ebu_space_t'(s);
            access(rows[1]);
        end
        $display("space test done");
        // Reset in mid-run, then traffic again
        rst_n = 1'b0;
        repeat (2) @(posedge clk) #1;
        `CHK("rerst_cs", 4'hf, cs_n)
        rst_n = 1'b1;
        access(rows[3]);
        $display("re-reset test done");
        summarize();
    end
endmodule
`default_nettype wire
